// >>> usb_ep_host_pkg.sv
package usb_ep_host_pkg;

    localparam int DEV_AW = 4;
    localparam int DEV_DW = 16;

    // Device register indices
    localparam logic [3:0] EP0_CONTROL_STATUS_ADDR = 4'h0;
    localparam logic [3:0] TX_PAYLOAD_LIMIT_ADDR = 4'h1;
    localparam logic [3:0] TX_EP_CONTROL_STATUS_ADDR = 4'h2;
    localparam logic [3:0] TX_BUFFER_SIZING_ADDR = 4'h3;

    // ep0_control_status fields
    localparam int EP0_RX_PACKET_PENDING = 0;
    localparam int EP0_STALL_SENT = 2;
    localparam int EP0_DATA_PHASE_DONE = 3;
    localparam int EP0_CONTROL_ABORTED = 4;
    localparam int EP0_STALL_REQUEST = 5;
    localparam int EP0_CONTROL_ABORT_ACK = 7;

    // tx_ep_control_status fields
    localparam int TX_PACKET_LOADED = 0;
    localparam int TX_BUFFER_OCCUPIED = 1;
    localparam int TX_BUFFER_DISCARD = 3;
    localparam int TX_STALL_REQUEST = 4;
    localparam int TX_STALL_SENT = 5;
    localparam int TX_TOGGLE_RESET = 6;
    localparam int TX_DMA_QUIET_MODE = 10;
    localparam int TX_FORCED_TOGGLE = 11;
    localparam int TX_DMA_REQUEST_EN = 12;
    localparam int TX_DIRECTION = 13;
    localparam int TX_ISO_SELECT = 14;

    // tx_buffer_sizing and payload limit fields
    localparam int SIZING_DOUBLE_BUFFER_EN = 4;
    localparam int PAYLOAD_LIMIT_BITS = 11;

    // cmd_data layout for the configure command
    localparam int CFG_DMA_BIT = 12;
    localparam int CFG_QUIET_BIT = 13;
    localparam int CFG_DBUF_BIT = 14;

    localparam logic [1:0] CFG_LAST_STEP = 2'h2;

    typedef enum logic [2:0] {
        CMD_CONFIGURE = 3'b000,
        CMD_COMMIT = 3'b001,
        CMD_DISCARD = 3'b010,
        CMD_STALL = 3'b011,
        CMD_UNSTALL = 3'b100,
        CMD_EP0_STALL = 3'b101,
        CMD_EP0_DONE = 3'b110
    } cmd_code_type;

    typedef struct packed {
        logic valid;
        logic we;
        logic [DEV_AW-1:0] addr;
        logic [DEV_DW-1:0] wdata;
    } dev_req_type;

    typedef struct packed {
        logic setup_pending;
        logic ep0_abort;
        logic tx_space;
        logic tx_stalled;
        logic cmd_err;
    } host_evt_type;

endpackage : usb_ep_host_pkg

// >>> usb_ep_host.sv
// Function
// - Abort seen: write abort acknowledge
// - Pending packet after abort is new SETUP
// - Software stall request forces STALL
// - Bulk needs iso and forced toggle zero
// - Toggle reset on configure or re-enable
// - Occupied flag; discard drops one packet
// - Set packet loaded; device clears when sent
// - Packet length within payload limit
// - Loaded with empty buffer sends null
// - Clear stall sent, keep stall request
`timescale 1ns/1ps
`default_nettype none
module usb_ep_host
    import usb_ep_host_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic cmd_valid,
    input wire cmd_code_type cmd_code,
    input wire logic [DEV_DW-1:0] cmd_data,
    output logic cmd_ready,
    output dev_req_type dev_req,
    input wire logic dev_ack,
    input wire logic [DEV_DW-1:0] dev_rdata,
    input wire logic dev_irq,
    output host_evt_type evt
);

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_EP0_RD = 3'b001,
        S_EP0_WR = 3'b010,
        S_TX_RD = 3'b011,
        S_TX_WR = 3'b100,
        S_CMD = 3'b101
    } state_type;

    state_type state, next_state;
    logic [1:0] step, next_step;
    cmd_code_type cmd, next_cmd;
    logic [DEV_DW-1:0] arg, next_arg;
    logic [PAYLOAD_LIMIT_BITS-1:0] limit, next_limit;
    logic dma_en, next_dma_en;
    logic quiet, next_quiet;
    logic stall_hold, next_stall_hold;
    logic next_cmd_ready;
    dev_req_type next_dev_req;
    host_evt_type next_evt;
    logic accept;
    logic [DEV_DW-1:0] tx_base;

    assign accept = cmd_valid && cmd_ready;

    // Iso and forced toggle always zero for bulk use
    always_comb
    begin
        tx_base = '0;
        tx_base[TX_DIRECTION] = 1'b1;
        tx_base[TX_DMA_REQUEST_EN] = dma_en;
        tx_base[TX_DMA_QUIET_MODE] = dma_en && quiet;
        tx_base[TX_STALL_REQUEST] = stall_hold;
    end

    always_comb
    begin
        next_state = state;
        next_step = step;
        next_cmd = cmd;
        next_arg = arg;
        next_limit = limit;
        next_dma_en = dma_en;
        next_quiet = quiet;
        next_stall_hold = stall_hold;
        next_dev_req = dev_req;
        next_evt = '0;
        unique case (state)
            S_IDLE:
            begin
                if (accept)
                begin
                    next_cmd = cmd_code;
                    next_arg = cmd_data;
                    next_step = 2'h0;
                    next_state = S_CMD;
                    next_dev_req.valid = 1'b1;
                    next_dev_req.we = 1'b1;
                    next_dev_req.addr = TX_EP_CONTROL_STATUS_ADDR;
                    next_dev_req.wdata = tx_base;
                    unique case (cmd_code)
                        CMD_CONFIGURE:
                        begin
                            next_dev_req.addr = TX_PAYLOAD_LIMIT_ADDR;
                            next_dev_req.wdata = {5'h00,
                                cmd_data[PAYLOAD_LIMIT_BITS-1:0]};
                        end
                        CMD_COMMIT:
                        begin
                            if (cmd_data[PAYLOAD_LIMIT_BITS-1:0] > limit)
                            begin
                                // Oversized packet refused, nothing written
                                next_dev_req.valid = 1'b0;
                                next_evt.cmd_err = 1'b1;
                                next_state = S_IDLE;
                            end
                            else
                            begin
                                // Zero length is fine: device sends null
                                next_dev_req.wdata[TX_PACKET_LOADED] =
                                    1'b1;
                            end
                        end
                        CMD_DISCARD:
                            next_dev_req.wdata[TX_BUFFER_DISCARD] =
                                1'b1;
                        CMD_STALL:
                        begin
                            next_stall_hold = 1'b1;
                            next_dev_req.wdata[TX_STALL_REQUEST] =
                                1'b1;
                        end
                        CMD_UNSTALL:
                        begin
                            next_stall_hold = 1'b0;
                            next_dev_req.wdata[TX_STALL_REQUEST] = 1'b0;
                            next_dev_req.wdata[TX_TOGGLE_RESET] =
                                1'b1;
                        end
                        CMD_EP0_STALL:
                        begin
                            next_dev_req.addr = EP0_CONTROL_STATUS_ADDR;
                            next_dev_req.wdata = '0;
                            next_dev_req.wdata[EP0_STALL_REQUEST] =
                                1'b1;
                        end
                        CMD_EP0_DONE:
                        begin
                            next_dev_req.addr = EP0_CONTROL_STATUS_ADDR;
                            next_dev_req.wdata = '0;
                            next_dev_req.wdata[EP0_DATA_PHASE_DONE] =
                                1'b1;
                        end
                        default:
                        begin
                            next_dev_req.valid = 1'b0;
                            next_evt.cmd_err = 1'b1;
                            next_state = S_IDLE;
                        end
                    endcase
                end
                else if (dev_irq)
                begin
                    // Endpoint 0 first: aborts outrank bulk traffic
                    next_state = S_EP0_RD;
                    next_dev_req.valid = 1'b1;
                    next_dev_req.we = 1'b0;
                    next_dev_req.addr = EP0_CONTROL_STATUS_ADDR;
                    next_dev_req.wdata = '0;
                end
            end
            S_EP0_RD:
            begin
                if (dev_ack)
                begin
                    next_evt.setup_pending =
                        dev_rdata[EP0_RX_PACKET_PENDING];
                    next_evt.ep0_abort = dev_rdata[EP0_STALL_SENT] ||
                        dev_rdata[EP0_CONTROL_ABORTED];
                    next_dev_req.we = 1'b1;
                    next_dev_req.wdata = '0;
                    // Writing zero to stall sent clears it
                    next_dev_req.wdata[EP0_CONTROL_ABORT_ACK] =
                        dev_rdata[EP0_CONTROL_ABORTED];
                    next_state = S_EP0_WR;
                    if (!dev_rdata[EP0_STALL_SENT] &&
                        !dev_rdata[EP0_CONTROL_ABORTED])
                    begin
                        next_dev_req.we = 1'b0;
                        next_dev_req.addr = TX_EP_CONTROL_STATUS_ADDR;
                        next_state = S_TX_RD;
                    end
                end
            end
            S_EP0_WR:
            begin
                if (dev_ack)
                begin
                    next_dev_req.we = 1'b0;
                    next_dev_req.addr = TX_EP_CONTROL_STATUS_ADDR;
                    next_dev_req.wdata = '0;
                    next_state = S_TX_RD;
                end
            end
            S_TX_RD:
            begin
                if (dev_ack)
                begin
                    next_evt.tx_space = !dev_rdata[TX_PACKET_LOADED];
                    next_evt.tx_stalled = dev_rdata[TX_STALL_SENT];
                    if (dev_rdata[TX_STALL_SENT])
                    begin
                        next_dev_req.we = 1'b1;
                        next_dev_req.wdata = tx_base;
                        next_state = S_TX_WR;
                    end
                    else
                    begin
                        next_dev_req.valid = 1'b0;
                        next_state = S_IDLE;
                    end
                end
            end
            S_TX_WR:
            begin
                if (dev_ack)
                begin
                    next_dev_req.valid = 1'b0;
                    next_state = S_IDLE;
                end
            end
            S_CMD:
            begin
                if (dev_ack)
                begin
                    if (cmd == CMD_CONFIGURE && step != CFG_LAST_STEP)
                    begin
                        next_step = step + 2'h1;
                        if (step == 2'h0)
                        begin
                            next_limit = arg[PAYLOAD_LIMIT_BITS-1:0];
                            next_dma_en = arg[CFG_DMA_BIT];
                            next_quiet = arg[CFG_QUIET_BIT];
                            next_dev_req.addr = TX_BUFFER_SIZING_ADDR;
                            next_dev_req.wdata = '0;
                            next_dev_req.wdata[SIZING_DOUBLE_BUFFER_EN] =
                                arg[CFG_DBUF_BIT];
                        end
                        else
                        begin
                            // New config also restarts toggle and drops stall
                            next_stall_hold = 1'b0;
                            next_dev_req.addr = TX_EP_CONTROL_STATUS_ADDR;
                            next_dev_req.wdata = tx_base;
                            next_dev_req.wdata[TX_STALL_REQUEST] = 1'b0;
                            next_dev_req.wdata[TX_TOGGLE_RESET] =
                                1'b1;
                            next_dev_req.wdata[TX_BUFFER_DISCARD] =
                                1'b1;
                        end
                    end
                    else
                    begin
                        next_dev_req.valid = 1'b0;
                        next_state = S_IDLE;
                    end
                end
            end
            default:
            begin
                next_dev_req.valid = 1'b0;
                next_state = S_IDLE;
            end
        endcase
        next_cmd_ready = next_state == S_IDLE;
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            state <= S_IDLE;
            step <= 2'h0;
            cmd <= CMD_CONFIGURE;
            arg <= '0;
            limit <= '0;
            dma_en <= 1'b0;
            quiet <= 1'b0;
            stall_hold <= 1'b0;
            dev_req <= '0;
            evt <= '0;
            cmd_ready <= 1'b0;
        end
        else
        begin
            state <= next_state;
            step <= next_step;
            cmd <= next_cmd;
            arg <= next_arg;
            limit <= next_limit;
            dma_en <= next_dma_en;
            quiet <= next_quiet;
            stall_hold <= next_stall_hold;
            dev_req <= next_dev_req;
            evt <= next_evt;
            cmd_ready <= next_cmd_ready;
        end
    end

    property p_abort_ack;
        @(posedge core_clk) disable iff (sys_rst)
        (state == S_EP0_RD && dev_ack && dev_rdata[EP0_CONTROL_ABORTED])
        |=> (dev_req.we && dev_req.addr == EP0_CONTROL_STATUS_ADDR &&
        dev_req.wdata[EP0_CONTROL_ABORT_ACK]);
    endproperty
    a_abort_ack: assert property (p_abort_ack)
        else $error("abort not acknowledged");

    property p_setup_flag;
        @(posedge core_clk) disable iff (sys_rst)
        (state == S_EP0_RD && dev_ack && dev_rdata[EP0_RX_PACKET_PENDING])
        |=> evt.setup_pending;
    endproperty
    a_setup_flag: assert property (p_setup_flag)
        else $error("pending setup not reported");

    property p_bulk_cfg;
        @(posedge core_clk) disable iff (sys_rst)
        (dev_req.valid && dev_req.we &&
        dev_req.addr == TX_EP_CONTROL_STATUS_ADDR)
        |-> (!dev_req.wdata[TX_ISO_SELECT] &&
        !dev_req.wdata[TX_FORCED_TOGGLE] && dev_req.wdata[TX_DIRECTION]);
    endproperty
    a_bulk_cfg: assert property (p_bulk_cfg)
        else $error("bulk configuration bits wrong");

    property p_stall_keep;
        @(posedge core_clk) disable iff (sys_rst)
        (state == S_TX_RD && dev_ack && dev_rdata[TX_STALL_SENT])
        |=> (dev_req.we && !dev_req.wdata[TX_STALL_SENT] &&
        dev_req.wdata[TX_STALL_REQUEST] == $past(stall_hold));
    endproperty
    a_stall_keep: assert property (p_stall_keep)
        else $error("stall sent clear changed stall request");

    property p_commit;
        @(posedge core_clk) disable iff (sys_rst)
        (accept && cmd_code == CMD_COMMIT &&
        cmd_data[PAYLOAD_LIMIT_BITS-1:0] <= limit)
        |=> (dev_req.valid && dev_req.wdata[TX_PACKET_LOADED])
        ##[0:20] (dev_ack && dev_req.valid);
    endproperty
    a_commit: assert property (p_commit)
        else $error("commit not issued");

    property p_oversize;
        @(posedge core_clk) disable iff (sys_rst)
        (accept && cmd_code == CMD_COMMIT &&
        cmd_data[PAYLOAD_LIMIT_BITS-1:0] > limit)
        |=> (evt.cmd_err && !dev_req.valid) ##1 cmd_ready;
    endproperty
    a_oversize: assert property (p_oversize)
        else $error("oversized packet not refused");

    property p_discard;
        @(posedge core_clk) disable iff (sys_rst)
        (accept && cmd_code == CMD_DISCARD)
        |=> (dev_req.wdata[TX_BUFFER_DISCARD] &&
        !dev_req.wdata[TX_PACKET_LOADED]);
    endproperty
    a_discard: assert property (p_discard)
        else $error("discard not written");

    property p_unstall;
        @(posedge core_clk) disable iff (sys_rst)
        (accept && cmd_code == CMD_UNSTALL)
        |=> (dev_req.wdata[TX_TOGGLE_RESET] &&
        !dev_req.wdata[TX_STALL_REQUEST]);
    endproperty
    a_unstall: assert property (p_unstall)
        else $error("re-enable without toggle reset");

    property p_ep0_stall;
        @(posedge core_clk) disable iff (sys_rst)
        (accept && cmd_code == CMD_EP0_STALL)
        |=> (dev_req.addr == EP0_CONTROL_STATUS_ADDR &&
        dev_req.wdata[EP0_STALL_REQUEST] && !cmd_ready);
    endproperty
    a_ep0_stall: assert property (p_ep0_stall)
        else $error("endpoint 0 stall not requested");

endmodule : usb_ep_host
`default_nettype wire

// >>> usb_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module usb_dev_model
    import usb_ep_host_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire dev_req_type dev_req,
    output logic dev_ack,
    output logic [DEV_DW-1:0] dev_rdata,
    output logic dev_irq,
    input wire logic [3:0] ack_delay,
    input wire logic ep0_token,
    input wire logic in_token,
    output logic [15:0] ep0_reg,
    output logic [15:0] limit_reg,
    output logic [15:0] txcsr_reg,
    output logic [15:0] sizing_reg,
    output logic [1:0] queued,
    output logic [3:0] toggle_cnt,
    output logic dma_req
);
    logic [15:0] ctl;
    logic [15:0] last_rd;
    logic [15:0] rd_val;
    logic [15:0] w;
    logic [3:0] wait_cnt;
    logic loaded;
    logic stall_sent;
    logic ep0_pend;
    logic tx_pend;
    logic dbuf;
    logic quiet;
    assign w = dev_req.wdata;
    assign dbuf = sizing_reg[SIZING_DOUBLE_BUFFER_EN];
    assign quiet = ctl[TX_DMA_REQUEST_EN] & ctl[TX_DMA_QUIET_MODE];
    assign txcsr_reg = ctl | {10'h0, stall_sent, 3'h0, queued != 2'h0, loaded};
    assign dma_req = ctl[TX_DMA_REQUEST_EN] & (queued < (dbuf ? 2'h2 : 2'h1));
    assign dev_irq = ep0_pend | tx_pend;
    // Idle bus shows no stale data
    assign dev_rdata = dev_ack ? rd_val : ~last_rd;
    always_comb
    begin
        case (dev_req.addr)
            EP0_CONTROL_STATUS_ADDR: rd_val = ep0_reg;
            TX_PAYLOAD_LIMIT_ADDR: rd_val = limit_reg;
            TX_EP_CONTROL_STATUS_ADDR: rd_val = txcsr_reg;
            default: rd_val = sizing_reg;
        endcase
    end
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            {dev_ack, wait_cnt, last_rd, ep0_reg, limit_reg} <= '0;
            {sizing_reg, ctl, queued, toggle_cnt} <= '0;
            {loaded, stall_sent, ep0_pend, tx_pend} <= '0;
        end
        else
        begin
            dev_ack <= dev_req.valid && !dev_ack && wait_cnt >= ack_delay;
            wait_cnt <= (dev_req.valid && !dev_ack) ? wait_cnt + 4'h1 : 4'h0;
            if (dev_ack && dev_req.valid && !dev_req.we)
            begin
                last_rd <= rd_val;
                if (dev_req.addr == EP0_CONTROL_STATUS_ADDR)
                    ep0_pend <= 1'b0;
                if (dev_req.addr == TX_EP_CONTROL_STATUS_ADDR)
                    tx_pend <= 1'b0;
            end
            else if (dev_ack && dev_req.valid)
            begin
                case (dev_req.addr)
                    EP0_CONTROL_STATUS_ADDR:
                    begin
                        if (w[7])
                            ep0_reg[4] <= 1'b0;
                        if (!w[2])
                            ep0_reg[2] <= 1'b0;
                        if (w[3])
                            ep0_reg[3] <= 1'b1;
                        if (w[5])
                        begin
                            ep0_reg[2] <= 1'b1;
                            ep0_pend <= 1'b1;
                        end
                    end
                    TX_PAYLOAD_LIMIT_ADDR: limit_reg <= w;
                    TX_BUFFER_SIZING_ADDR: sizing_reg <= w;
                    default:
                    begin
                        ctl <= w & 16'h7c10;
                        if (!w[5])
                            stall_sent <= 1'b0;
                        if (w[6])
                            toggle_cnt <= toggle_cnt + 4'h1;
                        if (w[3] && queued != 2'h0)
                            queued <= queued - 2'h1;
                        else if (w[0] && queued < 2'h2)
                        begin
                            // Empty load still counts as a packet
                            queued <= queued + 2'h1;
                            loaded <= !(dbuf && queued == 2'h0);
                            if (dbuf && queued == 2'h0 && !quiet)
                                tx_pend <= 1'b1;
                        end
                    end
                endcase
            end
            if (in_token && ctl[TX_STALL_REQUEST])
            begin
                stall_sent <= 1'b1;
                tx_pend <= 1'b1;
            end
            else if (in_token && queued != 2'h0)
            begin
                queued <= queued - 2'h1;
                loaded <= 1'b0;
                if (!quiet)
                    tx_pend <= 1'b1;
            end
            if (ep0_token)
            begin
                ep0_pend <= 1'b1;
                // A token after data phase done is answered with STALL; otherwise it aborts the control transfer as a new SETUP
                if (ep0_reg[3])
                begin
                    ep0_reg[2] <= 1'b1;
                    ep0_reg[3] <= 1'b0;
                end
                else
                    {ep0_reg[4], ep0_reg[0]} <= 2'h3;
            end
        end
    end
endmodule : usb_dev_model
`default_nettype wire

// >>> usb_ep_host_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module usb_ep_host_tb_top;
    import usb_ep_host_pkg::*;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic cmd_valid = 1'b0;
    cmd_code_type cmd_code = CMD_CONFIGURE;
    logic [15:0] cmd_data = 16'h0;
    logic [3:0] ack_delay = 4'h0;
    logic ep0_token = 1'b0;
    logic in_token = 1'b0;
    logic cmd_ready, dev_ack, dev_irq, dma_req;
    logic [15:0] dev_rdata, ep0_reg, limit_reg, txcsr_reg, sizing_reg;
    logic [1:0] queued;
    logic [3:0] toggle_cnt;
    dev_req_type dev_req;
    host_evt_type evt;
    int mismatches = 0;
    int total_checks = 0;
    int n_abort = 0, n_setup = 0, n_space = 0, n_stall = 0, n_err = 0, s;
    always #10 core_clk = ~core_clk;
    always @(posedge core_clk)
    begin
        n_abort <= n_abort + int'(evt.ep0_abort === 1'b1);
        n_setup <= n_setup + int'(evt.setup_pending === 1'b1);
        n_space <= n_space + int'(evt.tx_space === 1'b1);
        n_stall <= n_stall + int'(evt.tx_stalled === 1'b1);
        n_err <= n_err + int'(evt.cmd_err === 1'b1);
    end
    usb_ep_host usb_ep_host_inst (.core_clk(core_clk), .sys_rst(sys_rst),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_data(cmd_data),
        .cmd_ready(cmd_ready), .dev_req(dev_req), .dev_ack(dev_ack),
        .dev_rdata(dev_rdata), .dev_irq(dev_irq), .evt(evt));
    usb_dev_model usb_dev_model_inst (.core_clk(core_clk), .sys_rst(sys_rst),
        .dev_req(dev_req), .dev_ack(dev_ack), .dev_rdata(dev_rdata),
        .dev_irq(dev_irq), .ack_delay(ack_delay), .ep0_token(ep0_token),
        .in_token(in_token), .ep0_reg(ep0_reg), .limit_reg(limit_reg),
        .txcsr_reg(txcsr_reg), .sizing_reg(sizing_reg), .queued(queued),
        .toggle_cnt(toggle_cnt), .dma_req(dma_req));
    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : conclude
    // Idle means no access, no pending interrupt, ready for a command
    task automatic settle();
        int quiet;
        quiet = 0;
        for (int i = 0; i < 300 && quiet < 4; i++)
        begin
            @(posedge core_clk);
            #1;
            if (cmd_ready === 1'b1 && dev_irq === 1'b0 && dev_req.valid === 1'b0)
                quiet++;
            else
                quiet = 0;
        end
        check("idle_within_bound", 16'(quiet), 16'h4);
        if (quiet < 4)
            conclude();
    endtask : settle
    task automatic send(input cmd_code_type code, input logic [15:0] data);
        logic taken;
        taken = 1'b0;
        @(posedge core_clk);
        cmd_valid <= 1'b1;
        cmd_code <= code;
        cmd_data <= data;
        for (int i = 0; i < 100 && !taken; i++)
        begin
            #1;
            taken = (cmd_ready === 1'b1);
            @(posedge core_clk);
        end
        cmd_valid <= 1'b0;
        check("cmd_taken", 16'(taken), 16'h1);
        if (!taken)
            conclude();
        settle();
    endtask : send
    task automatic token(input logic ep0);
        @(posedge core_clk);
        if (ep0)
            ep0_token <= 1'b1;
        else
            in_token <= 1'b1;
        @(posedge core_clk);
        ep0_token <= 1'b0;
        in_token <= 1'b0;
        settle();
    endtask : token
    task automatic t_config();
        ack_delay <= 4'h5;
        send(CMD_CONFIGURE, 16'h4040);
        ack_delay <= 4'h0;
        check("limit", limit_reg, 16'h0040);
        check("sizing", sizing_reg, 16'h0010);
        check("csr_mode", txcsr_reg & 16'h7c10, 16'h2000);
        check("toggle_resets", 16'(toggle_cnt), 16'h1);
        check("dma_req_off", 16'(dma_req), 16'h0);
        $display("test config done");
    endtask : t_config
    task automatic t_dbuf();
        s = n_space;
        send(CMD_COMMIT, 16'h0000);
        check("queued_null", 16'(queued), 16'h1);
        check("loaded_cleared", txcsr_reg & 16'h1, 16'h0);
        check("space_evt", 16'(n_space), 16'(s + 1));
        send(CMD_COMMIT, 16'h0040);
        check("queued_two", 16'(queued), 16'h2);
        check("loaded_full", txcsr_reg & 16'h3, 16'h3);
        s = n_err;
        send(CMD_COMMIT, 16'h0041);
        check("oversize_err", 16'(n_err), 16'(s + 1));
        check("queued_kept", 16'(queued), 16'h2);
        s = n_space;
        token(1'b0);
        check("sent_one", 16'(queued), 16'h1);
        check("space_after_send", 16'(n_space), 16'(s + 1));
        send(CMD_DISCARD, 16'h0000);
        check("discarded", txcsr_reg & 16'h3, 16'h0);
        $display("test double buffer done");
    endtask : t_dbuf
    task automatic t_stall();
        s = n_stall;
        send(CMD_STALL, 16'h0000);
        check("stall_req", txcsr_reg & 16'h10, 16'h10);
        token(1'b0);
        check("stall_evt", 16'(n_stall), 16'(s + 1));
        check("stall_ack", txcsr_reg & 16'h30, 16'h10);
        token(1'b0);
        check("stall_retry", 16'(n_stall), 16'(s + 2));
        send(CMD_UNSTALL, 16'h0000);
        check("unstalled", txcsr_reg & 16'h10, 16'h0);
        check("toggle_again", 16'(toggle_cnt), 16'h2);
        $display("test stall done");
    endtask : t_stall
    task automatic t_ep0();
        s = n_abort;
        send(CMD_EP0_STALL, 16'h0000);
        check("ep0_stall_served", ep0_reg & 16'h4, 16'h0);
        send(CMD_EP0_DONE, 16'h0000);
        check("phase_done", ep0_reg & 16'h8, 16'h8);
        token(1'b1);
        check("late_token", ep0_reg & 16'h1c, 16'h0);
        check("ep0_stall_evts", 16'(n_abort), 16'(s + 2));
        token(1'b1);
        check("abort_evt", 16'(n_abort), 16'(s + 3));
        check("setup_evt", 16'(n_setup), 16'h1);
        check("abort_acked", ep0_reg & 16'h10, 16'h0);
        s = n_err;
        send(cmd_code_type'(3'h7), 16'h0000);
        check("bad_code_err", 16'(n_err), 16'(s + 1));
        $display("test endpoint zero done");
    endtask : t_ep0
    task automatic t_dma();
        send(CMD_CONFIGURE, 16'h3200);
        check("csr_dma", txcsr_reg & 16'h7c10, 16'h3400);
        check("dma_space", 16'(dma_req), 16'h1);
        send(CMD_COMMIT, 16'h0200);
        check("dma_full", 16'(dma_req), 16'h0);
        s = n_space;
        token(1'b0);
        check("quiet_send", 16'(n_space), 16'(s));
        check("dma_again", 16'(dma_req), 16'h1);
        $display("test dma done");
    endtask : t_dma
    initial
    begin
        repeat (16) @(posedge core_clk);
        check("req_in_reset", 16'(dev_req.valid), 16'h0);
        sys_rst <= 1'b0;
        repeat (2) @(posedge core_clk);
        t_config();
        t_dbuf();
        t_stall();
        t_ep0();
        t_dma();
        conclude();
    end
endmodule : usb_ep_host_tb_top
`default_nettype wire
